//--- src/lcmon_top.sv
`timescale 1ns/1ps
module lcmon_top
  import lcmon_pkg::*;
#(
  parameter int MON_SLOT = MON_SLOT_CYC,
  parameter int ERR_WIN = 16
) (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESET_N_IN,
  // Coefficient and limit writes from the host interface
  input wire logic REG_WR_IN,
  input wire logic [3:0] REG_SEL_IN,
  input wire logic [7:0] REG_DATA_IN,
  // Switching cycle and loop error
  input wire logic CYCLE_START_IN,
  input wire logic signed [7:0] VERR_IN,
  // Shared converter
  input wire logic ADC_DONE_IN,
  input wire logic [7:0] ADC_DATA_IN,
  output logic ADC_START_OUT,
  output logic [1:0] ADC_CHAN_OUT,
  // Duty output
  output logic [7:0] DUTY_OUT,
  output logic DUTY_VALID_OUT,
  // Register readback
  output logic [7:0] DUTY_LIMIT_REG_OUT,
  output logic [7:0] VOUT_MONITOR_OUT,
  output logic [7:0] IOUT_MONITOR_OUT,
  output logic [7:0] TEMP_MONITOR_OUT
);
  // ----------------------------------------
  // Register selects
  // ----------------------------------------
  localparam logic [3:0] SEL_DLIM = 4'h0;
  localparam logic [3:0] SEL_DEN1 = 4'h9;
  localparam logic [3:0] SEL_DEN2 = 4'ha;
  localparam logic [3:0] SEL_DEN3 = 4'hb;

  function automatic logic signed [ACC_W-1:0] mul_s(input logic signed [15:0] c,
                                                    input logic signed [ACC_W-1:0] x);
    logic signed [ACC_W+15:0] p;
    p = c * x;
    mul_s = ACC_W'(p >>> FRAC_W);
  endfunction : mul_s

  logic [7:0] duty_limit_reg_q;
  logic [7:0] num_hi_q [4];
  logic [7:0] num_lo_q [4];
  logic [7:0] den_q [3];
  logic signed [15:0] num_act_q [4];
  logic signed [15:0] den_act_q [3];

  // ----------------------------------------
  // Host-written registers
  // ----------------------------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      duty_limit_reg_q <= DLIM_RST;
      for (int i = 0; i < 4; i++) begin
        num_hi_q[i] <= COEF_RST;
        num_lo_q[i] <= COEF_RST;
      end
      for (int i = 0; i < 3; i++) begin
        den_q[i] <= COEF_RST;
      end
    end else if (REG_WR_IN) begin
      if (REG_SEL_IN == SEL_DLIM) begin
        duty_limit_reg_q <= REG_DATA_IN;
      end
      for (int i = 0; i < 4; i++) begin
        if (REG_SEL_IN == 4'(1 + 2 * i)) begin
          num_hi_q[i] <= REG_DATA_IN;
        end
        if (REG_SEL_IN == 4'(2 + 2 * i)) begin
          num_lo_q[i] <= REG_DATA_IN;
        end
      end
      if (REG_SEL_IN == SEL_DEN1) den_q[0] <= REG_DATA_IN;
      if (REG_SEL_IN == SEL_DEN2) den_q[1] <= REG_DATA_IN;
      if (REG_SEL_IN == SEL_DEN3) den_q[2] <= REG_DATA_IN;
    end
  end

  // ----------------------------------------
  // Coefficients taken at cycle boundary
  // ----------------------------------------
  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      for (int i = 0; i < 4; i++) num_act_q[i] <= 16'h0000;
      for (int i = 0; i < 3; i++) den_act_q[i] <= 16'h0000;
    end else if (CYCLE_START_IN) begin
      for (int i = 0; i < 4; i++) num_act_q[i] <= {num_hi_q[i], num_lo_q[i]};
      for (int i = 0; i < 3; i++) den_act_q[i] <= {{8{den_q[i][7]}}, den_q[i]};
    end
  end

  // ----------------------------------------
  // Third-order filter: 3 poles, 3 zeros
  // ----------------------------------------
  logic signed [ACC_W-1:0] x_q [3];
  logic signed [ACC_W-1:0] y_q [3];
  logic signed [ACC_W-1:0] x0;
  logic signed [ACC_W-1:0] y_d;
  logic [7:0] lim;
  logic [7:0] duty_d;
  logic sat_en;

  assign lim = {1'b0, duty_limit_reg_q[DLIM_LIM_MSB:0]};
  assign sat_en = duty_limit_reg_q[DLIM_SATEN_BIT];

  always_comb begin
    x0 = ACC_W'(VERR_IN);
    // y = C0x0+C1x1+C2x2+C3x3 - (B1y1+B2y2+B3y3); integrator pole from B1
    y_d = mul_s(num_act_q[0], x0) + mul_s(num_act_q[1], x_q[0])
        + mul_s(num_act_q[2], x_q[1]) + mul_s(num_act_q[3], x_q[2])
        - mul_s(den_act_q[0], y_q[0]) - mul_s(den_act_q[1], y_q[1])
        - mul_s(den_act_q[2], y_q[2]);
    if (y_d < 0) begin
      duty_d = 8'h00;
    end else if (y_d > ACC_W'(lim)) begin
      duty_d = lim;
    end else begin
      duty_d = y_d[7:0];
    end
    if (sat_en && (VERR_IN > 8'(ERR_WIN))) begin
      duty_d = lim;
    end else if (sat_en && (VERR_IN < -8'(ERR_WIN))) begin
      duty_d = 8'h00;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      for (int i = 0; i < 3; i++) begin
        x_q[i] <= '0;
        y_q[i] <= '0;
      end
      DUTY_OUT <= 8'h00;
      DUTY_VALID_OUT <= 1'b0;
    end else begin
      DUTY_VALID_OUT <= CYCLE_START_IN;
      if (CYCLE_START_IN) begin
        x_q[0] <= x0;
        x_q[1] <= x_q[0];
        x_q[2] <= x_q[1];
        // Feed clamped value back so the integrator cannot wind up
        y_q[0] <= ACC_W'(duty_d);
        y_q[1] <= y_q[0];
        y_q[2] <= y_q[1];
        DUTY_OUT <= duty_d;
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) DUTY_LIMIT_REG_OUT <= DLIM_RST;
    else DUTY_LIMIT_REG_OUT <= duty_limit_reg_q;
  end

  // ----------------------------------------
  // Monitor sequencer on shared converter
  // ----------------------------------------
  logic [31:0] slot_cnt_q;
  logic busy_q;
  logic [7:0] temp_q;

  function automatic logic [7:0] temp_corr(input logic [7:0] i, input logic [7:0] t);
    logic [16:0] p;
    // Resistance rises with temperature, so scale the reading down as it warms
    p = 17'(i) * 17'(9'h100 - {1'b0, t[7:1]} + 9'(TCOMP_REF >> 1));
    temp_corr = (p[16:8] > 9'h0ff) ? 8'hff : p[15:8];
  endfunction : temp_corr

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      slot_cnt_q <= '0;
      busy_q <= 1'b0;
      ADC_START_OUT <= 1'b0;
      ADC_CHAN_OUT <= LCM_CH_VOUT;
    end else begin
      ADC_START_OUT <= 1'b0;
      if (slot_cnt_q >= 32'(MON_SLOT - 1)) begin
        slot_cnt_q <= '0;
        if (!busy_q) begin
          ADC_START_OUT <= 1'b1;
          busy_q <= 1'b1;
        end
      end else begin
        slot_cnt_q <= slot_cnt_q + 32'h1;
      end
      if (busy_q && ADC_DONE_IN) begin
        busy_q <= 1'b0;
        case (ADC_CHAN_OUT)
          LCM_CH_VOUT: ADC_CHAN_OUT <= LCM_CH_IOUT;
          LCM_CH_IOUT: ADC_CHAN_OUT <= LCM_CH_TEMP;
          LCM_CH_TEMP: ADC_CHAN_OUT <= LCM_CH_VOUT;
          default: ADC_CHAN_OUT <= LCM_CH_VOUT;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RESET_N_IN) begin
      VOUT_MONITOR_OUT <= MON_RST;
      IOUT_MONITOR_OUT <= MON_RST;
      TEMP_MONITOR_OUT <= MON_RST;
      temp_q <= MON_RST;
    end else if (busy_q && ADC_DONE_IN) begin
      case (ADC_CHAN_OUT)
        LCM_CH_VOUT: VOUT_MONITOR_OUT <= ADC_DATA_IN;
        LCM_CH_IOUT: IOUT_MONITOR_OUT <= temp_corr(ADC_DATA_IN, temp_q);
        LCM_CH_TEMP: begin
          TEMP_MONITOR_OUT <= ADC_DATA_IN;
          temp_q <= ADC_DATA_IN;
        end
        default: temp_q <= temp_q;
      endcase
    end
  end
endmodule : lcmon_top

//--- src/lcmon_pkg.sv
// Functional notes
// - The saturation feedforward enable sits in the duty-limit register, written by the host.
// - The compensator is a third-order transfer function with three zeros and three poles.
// - The first pole integrates and the third pole low-pass filters switching noise.
// - Four numerator and three denominator coefficients set the pole and zero positions.
// - Numerator coefficients are high/low register pairs, denominators single registers.
// - One shared 8-bit converter digitises output voltage, output current and temperature.
// - Each monitored quantity is sampled at no less than 700 Hz.
// - The voltage, current and temperature monitor registers always hold the latest results.
// - Each current reading is corrected with the latest temperature reading.
// - Error outside the setpoint window forces duty to zero or limit within one switching cycle.
// - The maximum duty cycle is held in the duty-limit register, written by the host.
package lcmon_pkg;
  // ----------------------------------------
  // Widths and field positions
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int ACC_W = 24;
  localparam int FRAC_W = 8;
  localparam int DLIM_SATEN_BIT = 7;
  localparam int DLIM_LIM_MSB = 6;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] DLIM_RST = 8'h40;
  localparam logic [7:0] COEF_RST = 8'h00;
  localparam logic [7:0] MON_RST = 8'h00;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int MON_MIN_HZ = 700;
  localparam int MON_CHANNELS = 3;
  // Cycles between conversion starts, a third of the longest time per quantity, rounded down
  localparam int MON_SLOT_CYC = CLK_HZ / (MON_MIN_HZ * MON_CHANNELS);
  localparam int TCOMP_REF = 8'h40;
  // ----------------------------------------
  // Monitor channel selection
  // ----------------------------------------
  typedef enum logic [1:0] {
    LCM_CH_VOUT = 2'b00,
    LCM_CH_IOUT = 2'b01,
    LCM_CH_TEMP = 2'b10
  } lcm_chan_e;
endpackage : lcmon_pkg

//--- verif/lcm_chk_sva.sv
`timescale 1ns/1ps
module lcm_chk
  import lcmon_pkg::*;
#(parameter int ERR_WIN = 16) (
  // Watched ports
  input wire logic REF_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic CYCLE_START_IN,
  input wire logic signed [7:0] VERR_IN,
  input wire logic ADC_DONE_IN,
  input wire logic [7:0] ADC_DATA_IN,
  input wire logic ADC_START_OUT,
  input wire logic [1:0] ADC_CHAN_OUT,
  input wire logic [7:0] DUTY_OUT,
  input wire logic DUTY_VALID_OUT,
  input wire logic [7:0] DUTY_LIMIT_REG_OUT,
  input wire logic [7:0] VOUT_MONITOR_OUT
);
  logic [7:0] lim;
  logic sat_en;
  logic sat_up;
  logic sat_dn;
  assign lim = {1'b0, DUTY_LIMIT_REG_OUT[DLIM_LIM_MSB:0]};
  // Readback lags one cycle, so the enable used at a boundary shows one cycle later
  assign sat_en = DUTY_LIMIT_REG_OUT[DLIM_SATEN_BIT];
  assign sat_up = CYCLE_START_IN && (VERR_IN > ERR_WIN);
  assign sat_dn = CYCLE_START_IN && (VERR_IN < -ERR_WIN);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  a_valid_follows: assert property (CYCLE_START_IN |=> DUTY_VALID_OUT)
    else $error("duty valid missing");
  a_valid_cause: assert property (DUTY_VALID_OUT |-> $past(CYCLE_START_IN))
    else $error("duty valid without boundary");
  a_duty_holds: assert property (!DUTY_VALID_OUT |-> $stable(DUTY_OUT))
    else $error("duty moved between boundaries");
  a_duty_clamp: assert property (DUTY_VALID_OUT |-> DUTY_OUT <= lim)
    else $error("duty above limit");
  a_sat_high: assert property (sat_up |=> !sat_en || DUTY_OUT == lim)
    else $error("duty not forced to limit");
  a_sat_low: assert property (sat_dn |=> !sat_en || DUTY_OUT == 8'h00)
    else $error("duty not forced to zero");
  a_start_pulse: assert property (ADC_START_OUT |=> !ADC_START_OUT)
    else $error("start longer than one cycle");
  a_vout_update: assert property (ADC_DONE_IN && ADC_CHAN_OUT == LCM_CH_VOUT
    |=> VOUT_MONITOR_OUT == $past(ADC_DATA_IN)) else $error("voltage monitor stale");
  c_sat: cover property (sat_up ##1 sat_en);
  c_done: cover property (ADC_DONE_IN);
  c_clamp: cover property (DUTY_VALID_OUT && DUTY_OUT == lim);
endmodule : lcm_chk
bind lcmon_top lcm_chk #(.ERR_WIN(ERR_WIN)) u_chk (.REF_CLK_IN(REF_CLK_IN),
  .RESET_N_IN(RESET_N_IN), .CYCLE_START_IN(CYCLE_START_IN), .VERR_IN(VERR_IN),
  .ADC_DONE_IN(ADC_DONE_IN), .ADC_DATA_IN(ADC_DATA_IN), .ADC_START_OUT(ADC_START_OUT),
  .ADC_CHAN_OUT(ADC_CHAN_OUT), .DUTY_OUT(DUTY_OUT), .DUTY_VALID_OUT(DUTY_VALID_OUT),
  .DUTY_LIMIT_REG_OUT(DUTY_LIMIT_REG_OUT), .VOUT_MONITOR_OUT(VOUT_MONITOR_OUT));

//--- verif/lcm_adc_model.sv
`timescale 1ns/1ps
module lcm_adc_model (
  // Converter handshake
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic [1:0] chan_in,
  // Quantities and latency
  input wire logic [7:0] v_in,
  input wire logic [7:0] i_in,
  input wire logic [7:0] t_in,
  input wire logic [3:0] lat_in,
  // Result
  output logic done_out,
  output logic [7:0] data_out
);
  initial begin
    done_out = 1'b0;
    data_out = 8'h00;
    forever begin
      @(posedge clk_in);
      if (start_in) begin
        repeat (lat_in) @(posedge clk_in);
        done_out <= 1'b1;
        data_out <= (chan_in == 2'h0) ? v_in : (chan_in == 2'h1) ? i_in : t_in;
        @(posedge clk_in);
        done_out <= 1'b0;
        data_out <= ~data_out;
      end
    end
  end
endmodule : lcm_adc_model

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk, rst_n, wr, st, adc_st, adc_dn, dv;
  logic [3:0] sel, lat;
  logic [1:0] ch;
  logic [7:0] dat, v, i, t, adc_d, duty, lim_r, vmon, imon, temp_monitor;
  logic signed [7:0] verr;
  int num_errors = 0;
  int n_checks = 0;
  lcmon_top #(.MON_SLOT(50), .ERR_WIN(16)) DUT (.REF_CLK_IN(clk), .RESET_N_IN(rst_n),
    .REG_WR_IN(wr), .REG_SEL_IN(sel), .REG_DATA_IN(dat), .CYCLE_START_IN(st),
    .VERR_IN(verr), .ADC_DONE_IN(adc_dn), .ADC_DATA_IN(adc_d), .ADC_START_OUT(adc_st),
    .ADC_CHAN_OUT(ch), .DUTY_OUT(duty), .DUTY_VALID_OUT(dv), .DUTY_LIMIT_REG_OUT(lim_r),
    .VOUT_MONITOR_OUT(vmon), .IOUT_MONITOR_OUT(imon), .TEMP_MONITOR_OUT(temp_monitor));
  lcm_adc_model adc (.clk_in(clk), .start_in(adc_st), .chan_in(ch), .v_in(v), .i_in(i),
    .t_in(t), .lat_in(lat), .done_out(adc_dn), .data_out(adc_d));
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(logic [3:0] s, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    sel <= s;
    dat <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic wr_lim(logic [7:0] d);
    wr_reg(4'h0, d);
    repeat (2) @(posedge clk);
    #1;
    chk(lim_r, d);
  endtask : wr_lim
  task automatic cyc(logic signed [7:0] e, logic [7:0] exp);
    @(posedge clk);
    st <= 1'b1;
    verr <= e;
    @(posedge clk);
    st <= 1'b0;
    #1;
    chk({7'h0, dv}, 8'h01);
    chk(duty, exp);
  endtask : cyc
  task automatic give_verdict;
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    {rst_n, wr, st, sel, dat, verr} = '0;
    v = 8'h5a;
    i = 8'h40;
    t = 8'h80;
    lat = 4'd2;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(lim_r, 8'h40);
    chk(duty, 8'h00);
    $display("test reset done");
    wr_lim(8'h85);
    wr_reg(4'h1, 8'h01);
    wr_reg(4'h2, 8'h00);
    cyc(8'sd10, 8'h00);
    cyc(8'sd10, 8'h05);
    wr_lim(8'h94);
    cyc(8'sd10, 8'h0a);
    cyc(-8'sd3, 8'h00);
    cyc(8'sd17, 8'h14);
    cyc(-8'sd17, 8'h00);
    wr_lim(8'h14);
    cyc(8'sd17, 8'h11);
    wr_reg(4'h4, 8'h80);
    cyc(8'sd4, 8'h04);
    cyc(8'sd4, 8'h06);
    wr_lim(8'h14);
    wr_reg(4'hc, 8'hff);
    repeat (2) @(posedge clk);
    #1;
    chk(lim_r, 8'h14);
    wr_reg(4'h5, 8'h01);
    wr_reg(4'h6, 8'h80);
    wr_reg(4'h7, 8'h01);
    wr_reg(4'h8, 8'h80);
    wr_reg(4'h9, 8'h80);
    wr_reg(4'ha, 8'h80);
    wr_reg(4'hb, 8'h80);
    cyc(8'sd0, 8'h02);
    cyc(8'sd0, 8'h12);
    $display("test filter done");
    repeat (400) @(posedge clk);
    #1;
    chk(vmon, 8'h5a);
    chk(imon, 8'h38);
    chk(temp_monitor, 8'h80);
    lat <= 4'd15;
    v <= 8'h33;
    repeat (400) @(posedge clk);
    #1;
    chk(vmon, 8'h33);
    $display("test monitor done");
    give_verdict();
  end
endmodule : tb_top
